// ==== logic/pid_device.sv ====
// device end: instruction decoder on the link clock, space access on clock
`timescale 1ns/1ns
`include "pid_cfg.svh"
module pid_device
	import pid_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	pid_link_if.device link,
	output logic mem_req,
	output logic mem_we,
	output logic mem_io,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic mem_enable
);
	// link-domain state
	pid_dev_state_t st_r, st_nxt;
	logic [7:0] op_r, op_nxt;
	logic [15:0] ptr_r, ptr_nxt;
	logic [63:0] key_r, key_nxt;
	logic [2:0] kcnt_r, kcnt_nxt;
	logic men_r, men_nxt;
	logic [2:0] gt_r, gt_nxt;
	logic rtgl_r, rtgl_nxt;
	logic awe_r, awe_nxt;
	logic aio_r, aio_nxt;
	logic [15:0] aaddr_r, aaddr_nxt;
	logic [7:0] awd_r, awd_nxt;
	logic txt_r, txt_nxt;
	logic [7:0] txd_r, txd_nxt;
	// link input synchronisers
	logic [11:0] sy_s1, sy_s2;
	logic v_s2, b_s2, e_s2, ack_s2;
	logic [7:0] d_s2;
	// clock-domain state
	logic rq_s1, rq_s2, rq_s3;
	logic mreq_r, mreq_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic men_s1, men_s2;
	pid_class_t cl_in, cl_op;
	logic [63:0] key_full;
	logic [7:0] css_rd;

	assign link.d2p_tgl = txt_r;
	assign link.d2p_data = txd_r;
	assign mem_req = mreq_r;
	assign mem_we = awe_r;
	assign mem_io = aio_r;
	assign mem_addr = aaddr_r;
	assign mem_wdata = awd_r;
	assign mem_enable = men_s2;

	// two-stage capture of programmer signals and the access acknowledge
	always_ff @(posedge link.link_clk or negedge rst_b) begin
		if (!rst_b) begin
			sy_s1 <= 12'h000;
			sy_s2 <= 12'h000;
		end else begin
			sy_s1 <= {ack_r, link.p2d_err, link.p2d_break, link.p2d_valid, link.p2d_data};
			sy_s2 <= sy_s1;
		end
	end

	assign {ack_s2, e_s2, b_s2, v_s2, d_s2} = sy_s2; // only second stage is read
	assign cl_in = pid_classify(d_s2);
	assign cl_op = pid_classify(op_r);
	assign key_full = {d_s2, key_r[63:8]};

	// control/status space read-out for the incoming instruction's address
	always_comb begin
		css_rd = 8'h00;
		case (d_s2[3:0])
			`PID_CSS_STATUS: css_rd[`PID_MEMEN_BIT] = men_r;
			`PID_CSS_GUARD: css_rd = {5'h00, gt_r};
			`PID_CSS_ID: css_rd = `PID_ID_CODE; // arbitrary identification value
			default: css_rd = 8'h00;
		endcase
	end

	// instruction decoder next state
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		ptr_nxt = ptr_r;
		key_nxt = key_r;
		kcnt_nxt = kcnt_r;
		men_nxt = men_r;
		gt_nxt = gt_r;
		rtgl_nxt = rtgl_r;
		awe_nxt = awe_r;
		aio_nxt = aio_r;
		aaddr_nxt = aaddr_r;
		awd_nxt = awd_r;
		txt_nxt = txt_r;
		txd_nxt = txd_r;
		case (st_r)
			PID_DS_IDLE: begin
				if (v_s2 && !b_s2) begin
					op_nxt = d_s2;
					case (cl_in)
						PID_CL_LD, PID_CL_IO_RD: begin
							rtgl_nxt = ~rtgl_r;
							awe_nxt = 1'b0;
							aio_nxt = (cl_in == PID_CL_IO_RD);
							aaddr_nxt = (cl_in == PID_CL_IO_RD) ?
								{10'h000, d_s2[6:5], d_s2[3:0]} : ptr_r;
							st_nxt = PID_DS_ACCESS;
						end
						PID_CL_CSS_RD: begin
							txt_nxt = ~txt_r;
							txd_nxt = css_rd;
						end
						PID_CL_KEY: begin
							kcnt_nxt = 3'h0;
							st_nxt = PID_DS_KEY;
						end
						PID_CL_BAD: st_nxt = PID_DS_ERROR;
						default: st_nxt = PID_DS_OPERAND;
					endcase
				end
			end
			PID_DS_OPERAND: begin
				if (v_s2 && !b_s2) begin
					st_nxt = PID_DS_IDLE;
					case (cl_op)
						PID_CL_PTR: begin
							ptr_nxt[{op_r[0], 3'h0} +: 8] = d_s2;
						end
						PID_CL_CSS_WR: begin
							if (op_r[3:0] == `PID_CSS_STATUS) begin
								men_nxt = men_r & d_s2[`PID_MEMEN_BIT];
							end else if (op_r[3:0] == `PID_CSS_GUARD) begin
								gt_nxt = d_s2[2:0];
							end
						end
						default: begin
							rtgl_nxt = ~rtgl_r;
							awe_nxt = 1'b1;
							aio_nxt = (cl_op == PID_CL_IO_WR);
							aaddr_nxt = (cl_op == PID_CL_IO_WR) ?
								{10'h000, op_r[6:5], op_r[3:0]} : ptr_r;
							awd_nxt = d_s2;
							st_nxt = PID_DS_ACCESS;
						end
					endcase
				end
			end
			PID_DS_KEY: begin
				if (v_s2 && !b_s2) begin
					key_nxt = key_full;
					kcnt_nxt = kcnt_r + 3'h1;
					if (kcnt_r == `PID_KEY_LAST) begin
						st_nxt = PID_DS_IDLE;
						if (key_full == `PID_KEY_VALUE) begin
							men_nxt = 1'b1;
						end
					end
				end
			end
			PID_DS_ACCESS: begin
				if (rtgl_r == ack_s2) begin
					st_nxt = PID_DS_IDLE;
					if (!awe_r) begin
						txt_nxt = ~txt_r;
						txd_nxt = rd_r;
					end
					if (op_r == `PID_OP_LD_INC || op_r == `PID_OP_ST_INC) begin
						ptr_nxt = ptr_r + 16'h0001;
					end
				end
			end
			PID_DS_ERROR: begin
				if (b_s2) begin
					st_nxt = PID_DS_IDLE;
				end
			end
			default: st_nxt = PID_DS_ERROR;
		endcase
		// any exception outside the error state aborts the message
		if ((e_s2 || b_s2) && st_r != PID_DS_ERROR) begin
			st_nxt = PID_DS_ERROR;
		end
	end

	// decoder registers; programming starts disabled
	always_ff @(posedge link.link_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= PID_DS_IDLE;
			op_r <= 8'h00;
			ptr_r <= 16'h0000;
			key_r <= 64'h0000000000000000;
			kcnt_r <= 3'h0;
			men_r <= `PID_STATUS_RST;
			gt_r <= `PID_GUARD_RST;
			rtgl_r <= 1'b0;
			awe_r <= 1'b0;
			aio_r <= 1'b0;
			aaddr_r <= 16'h0000;
			awd_r <= 8'h00;
			txt_r <= 1'b0;
			txd_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			ptr_r <= ptr_nxt;
			key_r <= key_nxt;
			kcnt_r <= kcnt_nxt;
			men_r <= men_nxt;
			gt_r <= gt_nxt;
			rtgl_r <= rtgl_nxt;
			awe_r <= awe_nxt;
			aio_r <= aio_nxt;
			aaddr_r <= aaddr_nxt;
			awd_r <= awd_nxt;
			txt_r <= txt_nxt;
			txd_r <= txd_nxt;
		end
	end

	// request toggle in, one-cycle access, acknowledge toggle out
	always_comb begin
		mreq_nxt = rq_s2 ^ rq_s3;
		rd_nxt = (mreq_r && !awe_r) ? mem_rdata : rd_r;
		ack_nxt = mreq_r ? ~ack_r : ack_r;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rq_s1 <= 1'b0;
			rq_s2 <= 1'b0;
			rq_s3 <= 1'b0;
			mreq_r <= 1'b0;
			ack_r <= 1'b0;
			rd_r <= 8'h00;
			men_s1 <= 1'b0;
			men_s2 <= 1'b0;
		end else begin
			rq_s1 <= rtgl_r;
			rq_s2 <= rq_s1;
			rq_s3 <= rq_s2;
			mreq_r <= mreq_nxt;
			ack_r <= ack_nxt;
			rd_r <= rd_nxt;
			men_s1 <= men_r;
			men_s2 <= men_s1;
		end
	end
endmodule

// ==== logic/pid_cfg.svh ====
// constants for the programming-link instruction decoder
`ifndef PID_CFG_SVH
`define PID_CFG_SVH
`define PID_OP_LD 8'h20
`define PID_OP_LD_INC 8'h24
`define PID_OP_ST 8'h60
`define PID_OP_ST_INC 8'h64
`define PID_OP_PTR 7'h34
`define PID_OP_CSS_RD 4'h8
`define PID_OP_CSS_WR 4'hc
`define PID_OP_KEY 8'he0
`define PID_IO_FLAG_BIT 4
`define PID_KEY_VALUE 64'h1289ab45cdd888ff
`define PID_KEY_LAST 3'h7
`define PID_CSS_STATUS 4'h0
`define PID_CSS_GUARD 4'h2
`define PID_CSS_ID 4'hf
`define PID_ID_CODE 8'h5a
`define PID_MEMEN_BIT 1
`define PID_STATUS_RST 1'b0
`define PID_GUARD_RST 3'h0
`define PID_LINK_DIV 3'h4
`define PID_GAP_CYCLES 4'h8
`define PID_RSP_TIMEOUT 8'h40
`endif

// ==== logic/pid_pkg.sv ====
// types and opcode classifier shared by both link ends
`include "pid_cfg.svh"
package pid_pkg;
	typedef enum logic [4:0] {
		PID_DS_IDLE = 5'h01,
		PID_DS_OPERAND = 5'h02,
		PID_DS_KEY = 5'h04,
		PID_DS_ACCESS = 5'h08,
		PID_DS_ERROR = 5'h10
	} pid_dev_state_t;

	typedef enum logic [3:0] {
		PID_PS_IDLE = 4'h1,
		PID_PS_SEND = 4'h2,
		PID_PS_WAIT = 4'h4,
		PID_PS_GAP = 4'h8
	} pid_prog_state_t;

	typedef enum logic [3:0] {
		PID_CL_LD, PID_CL_ST, PID_CL_PTR, PID_CL_IO_RD, PID_CL_IO_WR,
		PID_CL_CSS_RD, PID_CL_CSS_WR, PID_CL_KEY, PID_CL_BAD
	} pid_class_t;

	// sorts an instruction byte into its class
	function automatic pid_class_t pid_classify(input logic [7:0] op);
		pid_class_t cl;
		cl = PID_CL_BAD;
		if (op == `PID_OP_LD || op == `PID_OP_LD_INC) begin
			cl = PID_CL_LD;
		end else if (op == `PID_OP_ST || op == `PID_OP_ST_INC) begin
			cl = PID_CL_ST;
		end else if (op[7:1] == `PID_OP_PTR) begin
			cl = PID_CL_PTR;
		end else if (op[`PID_IO_FLAG_BIT]) begin
			cl = op[7] ? PID_CL_IO_WR : PID_CL_IO_RD;
		end else if (op[7:4] == `PID_OP_CSS_RD) begin
			cl = PID_CL_CSS_RD;
		end else if (op[7:4] == `PID_OP_CSS_WR) begin
			cl = PID_CL_CSS_WR;
		end else if (op == `PID_OP_KEY) begin
			cl = PID_CL_KEY;
		end
		return cl;
	endfunction

	// read-type instructions get one byte back from the device
	function automatic logic pid_is_read(input logic [7:0] op);
		pid_class_t cl;
		cl = pid_classify(op);
		return cl == PID_CL_LD || cl == PID_CL_IO_RD || cl == PID_CL_CSS_RD;
	endfunction
endpackage

// ==== logic/pid_link_if.sv ====
// byte-level programming link between programmer and device
`timescale 1ns/1ns
interface pid_link_if;
	logic link_clk;
	logic p2d_valid;
	logic [7:0] p2d_data;
	logic p2d_break;
	logic p2d_err;
	logic d2p_tgl;
	logic [7:0] d2p_data;

	modport device (
		input link_clk,
		input p2d_valid,
		input p2d_data,
		input p2d_break,
		input p2d_err,
		output d2p_tgl,
		output d2p_data
	);

	modport programmer (
		output link_clk,
		output p2d_valid,
		output p2d_data,
		output p2d_break,
		output p2d_err,
		input d2p_tgl,
		input d2p_data
	);
endinterface

// ==== logic/pid_programmer.sv ====
// programmer end: makes the link clock and sends instruction messages
`timescale 1ns/1ns
`include "pid_cfg.svh"
module pid_programmer
	import pid_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	pid_link_if.programmer link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_op,
	input wire logic [7:0] cmd_wdata,
	input wire logic [63:0] cmd_key,
	input wire logic cmd_break,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_timeout
);
	pid_prog_state_t st_r, st_nxt;
	logic [2:0] dcnt_r, dcnt_nxt;
	logic lclk_r, lclk_nxt;
	logic [7:0] op_r, op_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic [63:0] key_r, key_nxt;
	logic brk_r, brk_nxt;
	logic [3:0] bidx_r, bidx_nxt;
	logic [3:0] blast_r, blast_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic pv_r, pv_nxt;
	logic [7:0] pd_r, pd_nxt;
	logic pb_r, pb_nxt;
	logic rv_r, rv_nxt;
	logic [7:0] rdat_r, rdat_nxt;
	logic rto_r, rto_nxt;
	logic tg_s1, tg_s2, tg_s3;
	logic [7:0] dd_s1, dd_s2;
	logic fall;

	assign link.link_clk = lclk_r;
	assign link.p2d_valid = pv_r;
	assign link.p2d_data = pd_r;
	assign link.p2d_break = pb_r;
	assign link.p2d_err = 1'b0;
	assign cmd_ready = (st_r == PID_PS_IDLE);
	assign rsp_valid = rv_r;
	assign rsp_data = rdat_r;
	assign rsp_timeout = rto_r;
	// link signals change where the link clock falls
	assign fall = lclk_r && (dcnt_r == `PID_LINK_DIV - 3'h1);

	// divider, message sender and answer wait
	always_comb begin
		dcnt_nxt = (dcnt_r == `PID_LINK_DIV - 3'h1) ? 3'h0 : dcnt_r + 3'h1;
		lclk_nxt = (dcnt_r == `PID_LINK_DIV - 3'h1) ? ~lclk_r : lclk_r;
		st_nxt = st_r;
		op_nxt = op_r;
		wd_nxt = wd_r;
		key_nxt = key_r;
		brk_nxt = brk_r;
		bidx_nxt = bidx_r;
		blast_nxt = blast_r;
		cnt_nxt = cnt_r;
		pv_nxt = fall ? 1'b0 : pv_r;
		pd_nxt = pd_r;
		pb_nxt = fall ? 1'b0 : pb_r;
		rv_nxt = 1'b0;
		rdat_nxt = rdat_r;
		rto_nxt = 1'b0;
		case (st_r)
			PID_PS_IDLE: begin
				// pointer setup and enable polling are the caller's order
				if (cmd_valid) begin
					op_nxt = cmd_op;
					wd_nxt = cmd_wdata;
					key_nxt = cmd_key;
					brk_nxt = cmd_break;
					bidx_nxt = 4'h0;
					if (cmd_break || pid_is_read(cmd_op)) begin
						blast_nxt = 4'h0;
					end else if (cmd_op == `PID_OP_KEY) begin
						blast_nxt = 4'h8;
					end else begin
						blast_nxt = 4'h1;
					end
					st_nxt = PID_PS_SEND;
				end
			end
			PID_PS_SEND: begin
				if (fall) begin
					pv_nxt = 1'b1;
					pb_nxt = brk_r;
					if (bidx_r == 4'h0) begin
						pd_nxt = brk_r ? 8'h00 : op_r;
					end else if (op_r == `PID_OP_KEY) begin
						pd_nxt = key_r[7:0]; // key goes low byte first
						key_nxt = {8'h00, key_r[63:8]};
					end else begin
						pd_nxt = wd_r;
					end
					bidx_nxt = bidx_r + 4'h1;
					cnt_nxt = 8'h00;
					if (bidx_r == blast_r) begin
						st_nxt = (!brk_r && pid_is_read(op_r)) ? PID_PS_WAIT : PID_PS_GAP;
					end
				end
			end
			PID_PS_WAIT: begin
				if (tg_s2 ^ tg_s3) begin
					rv_nxt = 1'b1;
					rdat_nxt = dd_s2;
					cnt_nxt = 8'h00;
					st_nxt = PID_PS_GAP;
				end else if (fall) begin
					cnt_nxt = cnt_r + 8'h01;
					if (cnt_r == `PID_RSP_TIMEOUT) begin
						rto_nxt = 1'b1;
						cnt_nxt = 8'h00;
						st_nxt = PID_PS_GAP;
					end
				end
			end
			PID_PS_GAP: begin
				// idle link cycles let the device finish its access
				if (fall) begin
					cnt_nxt = cnt_r + 8'h01;
					if (cnt_r == {4'h0, `PID_GAP_CYCLES}) begin
						st_nxt = PID_PS_IDLE;
					end
				end
			end
			default: st_nxt = PID_PS_IDLE;
		endcase
	end

	// registers, answer toggle and data synchronisers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= PID_PS_IDLE;
			dcnt_r <= 3'h0;
			lclk_r <= 1'b0;
			op_r <= 8'h00;
			wd_r <= 8'h00;
			key_r <= 64'h0000000000000000;
			brk_r <= 1'b0;
			bidx_r <= 4'h0;
			blast_r <= 4'h0;
			cnt_r <= 8'h00;
			pv_r <= 1'b0;
			pd_r <= 8'h00;
			pb_r <= 1'b0;
			rv_r <= 1'b0;
			rdat_r <= 8'h00;
			rto_r <= 1'b0;
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
			dd_s1 <= 8'h00;
			dd_s2 <= 8'h00;
		end else begin
			st_r <= st_nxt;
			dcnt_r <= dcnt_nxt;
			lclk_r <= lclk_nxt;
			op_r <= op_nxt;
			wd_r <= wd_nxt;
			key_r <= key_nxt;
			brk_r <= brk_nxt;
			bidx_r <= bidx_nxt;
			blast_r <= blast_nxt;
			cnt_r <= cnt_nxt;
			pv_r <= pv_nxt;
			pd_r <= pd_nxt;
			pb_r <= pb_nxt;
			rv_r <= rv_nxt;
			rdat_r <= rdat_nxt;
			rto_r <= rto_nxt;
			tg_s1 <= link.d2p_tgl;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
			dd_s1 <= link.d2p_data;
			dd_s2 <= dd_s1;
		end
	end
endmodule

// ==== tb/pid_props.sv ====
// link-level property checker for the programming link
`timescale 1ns/1ns
`include "pid_cfg.svh"
module pid_props (
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic p2d_valid,
	input wire logic [7:0] p2d_data,
	input wire logic p2d_break,
	input wire logic p2d_err,
	input wire logic d2p_tgl,
	input wire logic [7:0] d2p_data
);
	logic prev_r, prev_nxt, err_r, err_nxt, first, op_rd, op_wr, op_key, op_bad;
	logic [7:0] d;
	// instruction byte decode
	assign d = p2d_data;
	assign first = p2d_valid && !prev_r && !p2d_break;
	assign op_rd = first && ((!d[7] && d[4]) || d == 8'h20 || d == 8'h24 || d[7:4] == 4'h8);
	assign op_wr = first && ((d[7] && d[4]) || d == 8'h60 || d == 8'h64 ||
		d[7:1] == 7'h34 || d[7:4] == 4'hc);
	assign op_key = first && d == `PID_OP_KEY;
	assign op_bad = first && !op_rd && !op_wr && !op_key;
	// expected error state: break toggles it, exceptions and unknown opcodes set it
	always_comb begin
		prev_nxt = p2d_valid;
		err_nxt = (err_r ^ (p2d_valid && p2d_break)) | p2d_err | op_bad;
	end
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			err_r <= err_nxt;
		end
	end
	default clocking @(posedge link_clk); endclocking
	default disable iff (!rst_b);
	property p_wr_operand;
		op_wr |=> p2d_valid && !p2d_break ##1 !p2d_valid;
	endproperty
	a_wr_operand: assert property (p_wr_operand) else $error("bad operand count");
	property p_key_len;
		op_key |=> p2d_valid [*8] ##1 !p2d_valid;
	endproperty
	a_key_len: assert property (p_key_len) else $error("bad key length");
	property p_rd_alone;
		op_rd |=> !p2d_valid;
	endproperty
	a_rd_alone: assert property (p_rd_alone) else $error("read op sent operand");
	property p_rd_answer;
		op_rd && !err_r |-> ##[1:12] $changed(d2p_tgl);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_wr_silent;
		op_wr || op_key |=> $stable(d2p_tgl) [*8];
	endproperty
	a_wr_silent: assert property (p_wr_silent) else $error("write answered");
	property p_err_silent;
		op_rd && err_r |=> $stable(d2p_tgl) [*8];
	endproperty
	a_err_silent: assert property (p_err_silent) else $error("answer in error");
	property p_break_byte;
		p2d_break |-> p2d_valid && p2d_data == 8'h00;
	endproperty
	a_break_byte: assert property (p_break_byte) else $error("bad break byte");
	property p_data_hold;
		$stable(d2p_tgl) |-> $stable(d2p_data);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("answer byte moved");
	property p_id_read;
		first && d == 8'h8f && !err_r |-> ##[1:12] ($changed(d2p_tgl) && d2p_data == `PID_ID_CODE);
	endproperty
	a_id_read: assert property (p_id_read) else $error("wrong id byte");
endmodule

// ==== tb/prog_iface_instruction_decoder_tb.sv ====
// bench joining programmer and device ends over the link
`timescale 1ns/1ns
`include "pid_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
$display("unexpected at %0t: %h %h", $time, a, b); end end
module prog_iface_instruction_decoder_tb;
	logic clock = 1'b0;
	logic rst_b = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_break = 1'b0;
	logic [7:0] cmd_op = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic [63:0] cmd_key = 64'h0;
	logic cmd_ready, rsp_valid, rsp_timeout, mem_req, mem_we, mem_io, mem_enable, to_seen;
	logic [7:0] rsp_data, mem_wdata, mem_rdata, got;
	logic [15:0] mem_addr;
	logic [7:0] ds [0:65535];
	logic [7:0] io [0:63];
	int fails = 0;
	int checks_done = 0;
	pid_link_if link();
	always #5 clock = ~clock;
	// data and io space behind the device
	assign mem_rdata = mem_io ? io[mem_addr[5:0]] : ds[mem_addr];
	always @(posedge clock) begin
		if (mem_req && mem_we && mem_io) io[mem_addr[5:0]] <= mem_wdata;
		if (mem_req && mem_we && !mem_io) ds[mem_addr] <= mem_wdata;
	end
	pid_programmer u_pid_programmer (.clock(clock), .rst_b(rst_b), .link(link),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_wdata(cmd_wdata), .cmd_key(cmd_key), .cmd_break(cmd_break),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout));
	pid_device u_pid_device (.clock(clock), .rst_b(rst_b), .link(link), .mem_req(mem_req),
		.mem_we(mem_we), .mem_io(mem_io), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_enable(mem_enable));
	pid_props u_pid_props (.rst_b(rst_b), .link_clk(link.link_clk),
		.p2d_valid(link.p2d_valid), .p2d_data(link.p2d_data), .p2d_break(link.p2d_break),
		.p2d_err(link.p2d_err), .d2p_tgl(link.d2p_tgl), .d2p_data(link.d2p_data));
	// verdict and end of run
	task end_of_test;
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one message through the programmer, keeps answer byte and timeout
	task xfer(input logic [7:0] op, input logic [7:0] wd, input logic brk);
		int n;
		n = 0;
		got = 8'h00;
		to_seen = 1'b0;
		cmd_op = op;
		cmd_wdata = wd;
		cmd_break = brk;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(posedge clock) #1 n++;
		end
		@(posedge clock) #1 cmd_valid = 1'b0;
		do begin
			@(posedge clock) #1 n++;
			if (rsp_valid === 1'b1) got = rsp_data;
			if (rsp_timeout === 1'b1) to_seen = 1'b1;
		end while (cmd_ready !== 1'b1 && n < 3000);
		if (n >= 3000) fails++;
	endtask
	// state right after reset
	task t_reset;
		`CHK(mem_enable, 1'b0)
		xfer(8'h80, 8'h00, 1'b0);
		`CHK(got[`PID_MEMEN_BIT], 1'b0)
	endtask
	// pointer bytes, indirect store and load with and without increment
	task t_ptr;
		ds[16'h1236] = 8'h11;
		ds[16'h1237] = 8'h22;
		xfer(8'h68, 8'h34, 1'b0);
		xfer(8'h69, 8'h12, 1'b0);
		xfer(8'h60, 8'ha5, 1'b0);
		`CHK(ds[16'h1234], 8'ha5)
		xfer(8'h64, 8'h3c, 1'b0);
		xfer(8'h64, 8'h77, 1'b0);
		`CHK(ds[16'h1234], 8'h3c)
		`CHK(ds[16'h1235], 8'h77)
		xfer(8'h20, 8'h00, 1'b0);
		`CHK(got, 8'h11)
		xfer(8'h24, 8'h00, 1'b0);
		`CHK(got, 8'h11)
		xfer(8'h20, 8'h00, 1'b0);
		`CHK(got, 8'h22)
	endtask
	// io writes and reads at the ends and middle of the space
	task t_io;
		logic [5:0] a;
		for (int i = 0; i < 3; i++) begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h2a : 6'h3f;
			xfer({1'b1, a[5:4], 1'b1, a[3:0]}, {2'b10, a}, 1'b0);
			`CHK(io[a], {2'b10, a})
			io[a] = ~io[a];
			xfer({1'b0, a[5:4], 1'b1, a[3:0]}, 8'h00, 1'b0);
			`CHK(got, {2'b01, ~a})
		end
	endtask
	// control space identity and guard value
	task t_css;
		xfer(8'h8f, 8'h00, 1'b0);
		`CHK(got, `PID_ID_CODE)
		xfer(8'hc2, 8'h05, 1'b0);
		xfer(8'h82, 8'h00, 1'b0);
		`CHK(got, 8'h05)
	endtask
	// wrong last key byte, right key with polling, then disable
	task t_key;
		cmd_key = `PID_KEY_VALUE ^ {1'b1, 63'h0};
		xfer(`PID_OP_KEY, 8'h00, 1'b0);
		xfer(8'h80, 8'h00, 1'b0);
		`CHK(got[`PID_MEMEN_BIT], 1'b0)
		cmd_key = `PID_KEY_VALUE;
		xfer(`PID_OP_KEY, 8'h00, 1'b0);
		for (int i = 0; i < 8 && got[`PID_MEMEN_BIT] !== 1'b1; i++) begin
			xfer(8'h80, 8'h00, 1'b0);
		end
		`CHK(got[`PID_MEMEN_BIT], 1'b1)
		`CHK(mem_enable, 1'b1)
		xfer(8'hc0, 8'h00, 1'b0);
		xfer(8'h80, 8'h00, 1'b0);
		`CHK(got[`PID_MEMEN_BIT], 1'b0)
		`CHK(mem_enable, 1'b0)
	endtask
	// break, then unknown opcode, each blocks answers until a break
	task t_err;
		for (int i = 0; i < 2; i++) begin
			xfer(8'h00, 8'h00, i == 0);
			xfer(8'h8f, 8'h00, 1'b0);
			`CHK(to_seen, 1'b1)
			xfer(8'h00, 8'h00, 1'b1);
			xfer(8'h8f, 8'h00, 1'b0);
			`CHK(got, `PID_ID_CODE)
		end
	endtask
	// main sequence
	initial begin
		// a real falling edge, so every asynchronous reset branch runs
		@(posedge clock) #1 rst_b = 1'b0;
		repeat (3) @(posedge clock);
		#1 rst_b = 1'b1;
		t_reset;
		t_ptr;
		t_io;
		t_css;
		t_key;
		t_err;
		end_of_test;
	end
	// watchdog against a hang
	initial begin
		#200000;
		fails++;
		end_of_test;
	end
endmodule
